/* card_clock_map.vh */
// Constant map for the card clock, mode and select latch block
`ifndef CARD_CLOCK_MAP_VH
`define CARD_CLOCK_MAP_VH

// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_INT_STATUS 8'h08
`define OFS_INT_MASK 8'h0C

// Control register fields
`define CTL_CLOCK_RUN 0
`define CTL_RESET 1'h1

// Status register fields
`define ST_SYNC_MODE 0
`define ST_SELECTED 1
`define ST_PRESENT 2
`define ST_POWER_REQ_N 3
`define ST_VOLT_SEL 4
`define ST_DIV_LO 5
`define ST_DIV_HI 6
`define ST_LOW_POWER 7
`define ST_ALERT_LOW 8
`define ST_WIDTH 9

// Interrupt event bits
`define EV_FAULT 0
`define EV_PRESENCE 1
`define EV_DESELECT 2
`define EV_WIDTH 3
`define EV_RESET 3'h0

// Latched host control vector positions
`define HC_POWER_REQ_N 0
`define HC_HOST_RESET 1
`define HC_LOW_POWER 2
`define HC_VOLT_SEL 3
`define HC_DIV_LO 4
`define HC_DIV_HI 5
`define HC_SYNC_MODE 6
`define HC_WIDTH 7
// Power request released, 5 V card, all else low
`define HC_RESET 7'h09

// Pin synchroniser vector positions above the host controls
`define PS_SELECT 7
`define PS_STROBE 8
`define PS_OSC 9
`define PS_HOST_LINE 10
`define PS_CARD_LINE 13
`define PS_WIDTH 16
// Lines idle high through pull-ups, power request high
`define PS_RESET 16'hFC09

// Divider select codes, {lo,hi}
`define DIV_BY_8 2'h0
`define DIV_BY_4 2'h1
`define DIV_BY_2 2'h3
`define DIV_BY_1 2'h2

// Open-drain line owner states
`define OWN_IDLE 2'h0
`define OWN_HOST 2'h1
`define OWN_CARD 2'h2
// Quiet edges after a release, longer than our echo through the synchroniser
`define ECHO_HOLD 3'h5

`endif

/* pin_sync.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
)(
	input wire clock,
	input wire reset,
	input wire clock_enable,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] stable
);
	reg [WIDTH-1:0] stage1_reg;
	reg [WIDTH-1:0] stage2_reg;
	reg [WIDTH-1:0] stage3_reg;
	reg [WIDTH-1:0] stable_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : bit_sync
			always @(posedge clock)
			begin
				if (reset)
				begin
					stage1_reg[i] <= RESET_VALUE[i];
					stage2_reg[i] <= RESET_VALUE[i];
					stage3_reg[i] <= RESET_VALUE[i];
					stable_reg[i] <= RESET_VALUE[i];
				end
				else if (clock_enable)
				begin
					stage1_reg[i] <= pin_in[i];
					stage2_reg[i] <= stage1_reg[i];
					stage3_reg[i] <= stage2_reg[i];
					// Only a level seen twice in a row is accepted
					if (stage2_reg[i] == stage3_reg[i])
						stable_reg[i] <= stage3_reg[i];
				end
			end
		end
	endgenerate

	assign stable = stable_reg;
endmodule

/* card_clock_select.v */
// Card clock divider, mode select, select latch and host pin isolation
`timescale 1ns/1ps
`include "card_clock_map.vh"
module card_clock_select #(
	parameter ADDR_WIDTH = 8
)(
	input wire clock,
	input wire reset,
	input wire clock_enable,
	input wire unit_select,
	input wire card_power_request_n,
	input wire host_reset_in,
	input wire low_power_request,
	input wire card_voltage_select,
	input wire divider_select_lo,
	input wire divider_select_hi,
	input wire sync_mode_select,
	input wire host_strobe,
	input wire oscillator_in,
	output wire oscillator_buffer_out,
	input wire host_card_data_in,
	output wire host_card_data_out,
	output wire host_card_data_oe_n,
	input wire host_aux_data_1_in,
	output wire host_aux_data_1_out,
	output wire host_aux_data_1_oe_n,
	input wire host_aux_data_2_in,
	output wire host_aux_data_2_out,
	output wire host_aux_data_2_oe_n,
	input wire card_data_in,
	output wire card_data_out,
	output wire card_data_oe_n,
	input wire card_aux_1_in,
	output wire card_aux_1_out,
	output wire card_aux_1_oe_n,
	input wire card_aux_2_in,
	output wire card_aux_2_out,
	output wire card_aux_2_oe_n,
	output wire host_alert_out,
	output wire host_alert_oe_n,
	input wire card_present,
	input wire sequencer_fault,
	input wire sequencer_reset_enable,
	input wire sequencer_clock_enable,
	output wire card_clock,
	output wire card_reset,
	output wire card_power_on_request,
	output wire card_voltage_5v,
	output wire low_power_mode,
	input wire [ADDR_WIDTH-1:0] bus_address,
	input wire [31:0] bus_write_data,
	input wire bus_write,
	input wire bus_read,
	output wire [31:0] bus_read_data,
	output wire interrupt
);
	wire [`PS_WIDTH-1:0] pins_raw;
	wire [`PS_WIDTH-1:0] pins;
	wire selected;
	wire strobe_level;
	wire osc_level;
	wire [2:0] host_low;
	wire [2:0] card_low;

	reg [`HC_WIDTH-1:0] hold_reg;
	reg [`HC_WIDTH-1:0] hold_next;
	wire [`HC_WIDTH-1:0] controls;

	reg osc_prev_reg;
	reg [2:0] div_count_reg;
	reg card_clock_reg;
	reg card_clock_next;
	reg card_reset_reg;
	reg card_reset_next;
	reg osc_buffer_reg;
	wire [1:0] div_code;
	wire osc_rise;
	wire sync_mode;

	reg [1:0] owner_reg [0:2];
	reg [2:0] drive_host_reg;
	reg [2:0] drive_card_reg;
	reg [2:0] quiet_reg [0:2];
	wire [2:0] line_free;

	reg alert_low_reg;
	reg alert_low_next;
	reg alert_prev_reg;
	reg present_prev_reg;
	reg selected_prev_reg;

	reg control_reg;
	reg [`EV_WIDTH-1:0] int_status_reg;
	reg [`EV_WIDTH-1:0] int_status_next;
	reg [`EV_WIDTH-1:0] int_mask_reg;
	reg [`EV_WIDTH-1:0] events;
	reg [31:0] read_data_reg;
	reg [31:0] read_data_next;
	wire [`ST_WIDTH-1:0] status_word;
	wire wr_control;
	wire wr_int_status;
	wire wr_int_mask;

	// All host pins arrive from outside the clock domain
	assign pins_raw = {card_aux_2_in, card_aux_1_in, card_data_in,
		host_aux_data_2_in, host_aux_data_1_in, host_card_data_in,
		oscillator_in, host_strobe, unit_select, sync_mode_select,
		divider_select_hi, divider_select_lo, card_voltage_select,
		low_power_request, host_reset_in, card_power_request_n};

	pin_sync #(
		.WIDTH(`PS_WIDTH),
		.RESET_VALUE(`PS_RESET)
	) u_pin_sync (
		.clock(clock),
		.reset(reset),
		.clock_enable(clock_enable),
		.pin_in(pins_raw),
		.stable(pins)
	);

	assign selected = pins[`PS_SELECT];
	assign strobe_level = pins[`PS_STROBE];
	assign osc_level = pins[`PS_OSC];
	assign host_low = ~pins[`PS_HOST_LINE+2:`PS_HOST_LINE];
	assign card_low = ~pins[`PS_CARD_LINE+2:`PS_CARD_LINE];

	// Select latch: follow pins while selected, freeze otherwise
	always @*
	begin
		hold_next = hold_reg;
		if (selected)
			hold_next = pins[`HC_WIDTH-1:0];
	end

	// Deselected cycle uses the held copy, not the moving pins
	assign controls = selected ? pins[`HC_WIDTH-1:0] : hold_reg;

	assign sync_mode = controls[`HC_SYNC_MODE];
	assign div_code = {controls[`HC_DIV_LO], controls[`HC_DIV_HI]};
	assign osc_rise = osc_level & ~osc_prev_reg;

	// Card clock and card reset source selection
	always @*
	begin
		card_clock_next = 1'b0;
		card_reset_next = 1'b0;
		if (sync_mode)
		begin
			card_clock_next = strobe_level;
			card_reset_next = controls[`HC_HOST_RESET];
		end
		else
		begin
			// Strobe is never looked at on this path
			if (sequencer_clock_enable && control_reg)
			begin
				if (div_code == `DIV_BY_8)
					card_clock_next = div_count_reg[2];
				else if (div_code == `DIV_BY_4)
					card_clock_next = div_count_reg[1];
				else if (div_code == `DIV_BY_2)
					card_clock_next = div_count_reg[0];
				else
					card_clock_next = osc_level;
			end
			if (sequencer_reset_enable)
				card_reset_next = controls[`HC_HOST_RESET];
		end
	end

	// Alert: presence while idle, fault during a power request
	always @*
	begin
		if (controls[`HC_POWER_REQ_N])
			alert_low_next = ~card_present;
		else
			alert_low_next = sequencer_fault;
	end

	always @(posedge clock)
	begin
		if (reset)
		begin
			hold_reg <= `HC_RESET;
			osc_prev_reg <= 1'b0;
			div_count_reg <= 3'h0;
			card_clock_reg <= 1'b0;
			card_reset_reg <= 1'b0;
			osc_buffer_reg <= 1'b0;
			alert_low_reg <= 1'b0;
		end
		else if (clock_enable)
		begin
			hold_reg <= hold_next;
			osc_prev_reg <= osc_level;
			if (osc_rise)
				div_count_reg <= div_count_reg + 3'h1;
			card_clock_reg <= card_clock_next;
			card_reset_reg <= card_reset_next;
			osc_buffer_reg <= osc_level;
			alert_low_reg <= alert_low_next;
		end
	end

	// Open-drain repeaters; ownership stops the two sides locking low
	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1)
		begin : line_rep
			// Our own low still lingers in the synchroniser after release
			assign line_free[i] = (quiet_reg[i] == 3'h0);
			always @(posedge clock)
			begin
				if (reset)
				begin
					owner_reg[i] <= `OWN_IDLE;
					drive_host_reg[i] <= 1'b0;
					drive_card_reg[i] <= 1'b0;
					quiet_reg[i] <= 3'h0;
				end
				else if (clock_enable)
				begin
					if (!selected)
					begin
						owner_reg[i] <= `OWN_IDLE;
						drive_host_reg[i] <= 1'b0;
						drive_card_reg[i] <= 1'b0;
						quiet_reg[i] <= `ECHO_HOLD;
					end
					else
					begin
						if (!line_free[i])
							quiet_reg[i] <= quiet_reg[i] - 3'h1;
						case (owner_reg[i])
							`OWN_IDLE:
							begin
								if (!line_free[i])
									owner_reg[i] <= `OWN_IDLE;
								else if (host_low[i])
								begin
									owner_reg[i] <= `OWN_HOST;
									drive_card_reg[i] <= 1'b1;
								end
								else if (card_low[i])
								begin
									owner_reg[i] <= `OWN_CARD;
									drive_host_reg[i] <= 1'b1;
								end
							end
							`OWN_HOST:
							begin
								if (!host_low[i])
								begin
									owner_reg[i] <= `OWN_IDLE;
									drive_card_reg[i] <= 1'b0;
									quiet_reg[i] <= `ECHO_HOLD;
								end
							end
							`OWN_CARD:
							begin
								if (!card_low[i])
								begin
									owner_reg[i] <= `OWN_IDLE;
									drive_host_reg[i] <= 1'b0;
									quiet_reg[i] <= `ECHO_HOLD;
								end
							end
							default:
							begin
								owner_reg[i] <= `OWN_IDLE;
								drive_host_reg[i] <= 1'b0;
								drive_card_reg[i] <= 1'b0;
							end
						endcase
					end
				end
			end
		end
	endgenerate

	// Open drain: the out value is always low, enables do the work
	assign host_card_data_out = 1'b0;
	assign host_aux_data_1_out = 1'b0;
	assign host_aux_data_2_out = 1'b0;
	assign card_data_out = 1'b0;
	assign card_aux_1_out = 1'b0;
	assign card_aux_2_out = 1'b0;
	assign host_card_data_oe_n = ~drive_host_reg[0];
	assign host_aux_data_1_oe_n = ~drive_host_reg[1];
	assign host_aux_data_2_oe_n = ~drive_host_reg[2];
	assign card_data_oe_n = ~drive_card_reg[0];
	assign card_aux_1_oe_n = ~drive_card_reg[1];
	assign card_aux_2_oe_n = ~drive_card_reg[2];

	assign host_alert_out = 1'b0;
	assign host_alert_oe_n = ~(alert_low_reg & selected);

	assign oscillator_buffer_out = osc_buffer_reg;
	assign card_clock = card_clock_reg;
	assign card_reset = card_reset_reg;
	assign card_power_on_request = ~hold_reg[`HC_POWER_REQ_N];
	assign card_voltage_5v = hold_reg[`HC_VOLT_SEL];
	// Low power is refused while a card session is requested
	assign low_power_mode = hold_reg[`HC_LOW_POWER] &
		hold_reg[`HC_POWER_REQ_N];

	// Register port
	assign wr_control = bus_write && (bus_address == `OFS_CONTROL);
	assign wr_int_status = bus_write &&
		(bus_address == `OFS_INT_STATUS);
	assign wr_int_mask = bus_write && (bus_address == `OFS_INT_MASK);

	assign status_word = {alert_low_reg, hold_reg[`HC_LOW_POWER],
		hold_reg[`HC_DIV_HI], hold_reg[`HC_DIV_LO],
		hold_reg[`HC_VOLT_SEL], hold_reg[`HC_POWER_REQ_N],
		card_present, selected, hold_reg[`HC_SYNC_MODE]};

	// Events; a set in the clearing cycle survives the clear
	always @*
	begin
		events = `EV_RESET;
		events[`EV_FAULT] = alert_low_reg & ~alert_prev_reg &
			~hold_reg[`HC_POWER_REQ_N];
		events[`EV_PRESENCE] = card_present ^ present_prev_reg;
		events[`EV_DESELECT] = selected_prev_reg & ~selected;
		int_status_next = int_status_reg;
		if (wr_int_status)
			int_status_next = int_status_next &
				~bus_write_data[`EV_WIDTH-1:0];
		int_status_next = int_status_next | events;
	end

	always @*
	begin
		read_data_next = 32'h0000_0000;
		if (bus_address == `OFS_CONTROL)
			read_data_next[`CTL_CLOCK_RUN] = control_reg;
		else if (bus_address == `OFS_STATUS)
			read_data_next[`ST_WIDTH-1:0] = status_word;
		else if (bus_address == `OFS_INT_STATUS)
			read_data_next[`EV_WIDTH-1:0] = int_status_reg;
		else if (bus_address == `OFS_INT_MASK)
			read_data_next[`EV_WIDTH-1:0] = int_mask_reg;
	end

	always @(posedge clock)
	begin
		if (reset)
		begin
			control_reg <= `CTL_RESET;
			int_status_reg <= `EV_RESET;
			int_mask_reg <= `EV_RESET;
			read_data_reg <= 32'h0000_0000;
			alert_prev_reg <= 1'b0;
			present_prev_reg <= 1'b0;
			selected_prev_reg <= 1'b0;
		end
		else if (clock_enable)
		begin
			if (wr_control)
				control_reg <= bus_write_data[`CTL_CLOCK_RUN];
			if (wr_int_mask)
				int_mask_reg <= bus_write_data[`EV_WIDTH-1:0];
			int_status_reg <= int_status_next;
			if (bus_read)
				read_data_reg <= read_data_next;
			else
				read_data_reg <= 32'h0000_0000;
			alert_prev_reg <= alert_low_reg;
			present_prev_reg <= card_present;
			selected_prev_reg <= selected;
		end
	end

	assign bus_read_data = read_data_reg;
	assign interrupt = |(int_status_reg & int_mask_reg);
endmodule

/* line_model.sv */
// Pull-up model of the host and card data lines
`timescale 1ns/1ps
module line_model (
	input wire [2:0] host_oe_n,
	input wire [2:0] card_oe_n,
	input wire [2:0] host_pull_n,
	input wire [2:0] card_pull_n,
	output wire [2:0] host_level,
	output wire [2:0] card_level
);
// Weak pull-ups: a released line reads high
assign host_level = host_oe_n & host_pull_n;
assign card_level = card_oe_n & card_pull_n;
endmodule

/* card_clock_select_checker.sv */
// Port assertions for the card clock, mode and select latch
`timescale 1ns/1ps
module clk_sel_checker (
	input wire clock,
	input wire reset,
	input wire clock_enable,
	input wire unit_select,
	input wire sync_mode_select,
	input wire host_strobe,
	input wire host_reset_in,
	input wire oscillator_in,
	input wire oscillator_buffer_out,
	input wire sequencer_reset_enable,
	input wire sequencer_clock_enable,
	input wire card_clock,
	input wire card_reset,
	input wire host_card_data_oe_n,
	input wire host_aux_data_1_oe_n,
	input wire host_aux_data_2_oe_n,
	input wire host_alert_oe_n,
	input wire bus_read,
	input wire [31:0] bus_read_data
);
default clocking cb @(posedge clock);
endclocking
default disable iff (reset || !clock_enable);
// Pins cross three sync stages, so causes must hold several cycles
wire sync_on = unit_select && sync_mode_select;
wire async_on = unit_select && !sync_mode_select;
wire lines_off = host_card_data_oe_n && host_aux_data_1_oe_n &&
	host_aux_data_2_oe_n;
osc_high_a: assert property (
	oscillator_in [*6] |-> oscillator_buffer_out) else $error("osc high");
osc_low_a: assert property (
	!oscillator_in [*6] |-> !oscillator_buffer_out) else $error("osc low");
strobe_copy_a: assert property (
	(sync_on && host_strobe) [*8] |-> card_clock) else $error("strobe");
reset_copy_a: assert property (
	(sync_on && host_reset_in) [*8] |-> card_reset) else $error("reset");
reset_follow_a: assert property (
	(async_on && sequencer_reset_enable && host_reset_in) [*8] |->
	card_reset) else $error("reset follow");
clock_gate_a: assert property (
	(async_on && !sequencer_clock_enable) [*8] |-> !card_clock)
	else $error("clock gate");
alert_release_a: assert property (
	!unit_select [*6] |-> host_alert_oe_n) else $error("alert held");
lines_release_a: assert property (
	!unit_select [*6] |-> lines_off) else $error("lines held");
read_pulse_a: assert property (
	!$past(bus_read) |-> bus_read_data == 32'h0) else $error("read");
cover property (sync_on && card_clock);
cover property (!host_alert_oe_n && unit_select);
cover property (bus_read ##1 bus_read_data != 32'h0);
endmodule
bind card_clock_select clk_sel_checker u_clk_sel_checker (.clock, .reset,
	.clock_enable, .unit_select, .sync_mode_select, .host_strobe,
	.host_reset_in, .oscillator_in, .oscillator_buffer_out,
	.sequencer_reset_enable, .sequencer_clock_enable, .card_clock,
	.card_reset, .host_card_data_oe_n, .host_aux_data_1_oe_n,
	.host_aux_data_2_oe_n, .host_alert_oe_n, .bus_read, .bus_read_data);

/* tb.sv */
// Self-checking bench for the card clock, mode and select latch
`timescale 1ns/1ps
module tb;
reg clock = 1'b0;
reg reset = 1'b1;
reg sel = 1'b1;
reg strobe = 1'b0;
reg present = 1'b1;
reg fault = 1'b0;
reg sre = 1'b0;
reg sce = 1'b1;
reg wr_s = 1'b0;
reg rd_s = 1'b0;
reg [6:0] hc = 7'h09;
reg [6:0] keep;
reg [3:0] oc = 4'h0;
reg [2:0] hp = 3'h7;
reg [2:0] cp = 3'h7;
reg [7:0] addr = 8'h00;
reg [31:0] wdata = 32'h0;
reg [31:0] d;
reg [7:0] lf = 8'h62;
integer err_count = 0;
integer comparisons = 0;
integer i;
wire [2:0] hoe, coe, hl, cl;
wire [31:0] rdata;
wire ck, cr, aoe, irq, vsel, pon, lpm, ob;
card_clock_select u_card_clock_select (
	.clock(clock), .reset(reset), .clock_enable(1'b1), .unit_select(sel),
	.card_power_request_n(hc[0]), .host_reset_in(hc[1]),
	.low_power_request(hc[2]), .card_voltage_select(hc[3]),
	.divider_select_lo(hc[4]), .divider_select_hi(hc[5]),
	.sync_mode_select(hc[6]), .host_strobe(strobe), .oscillator_in(oc[3]),
	.oscillator_buffer_out(ob), .host_card_data_in(hl[0]),
	.host_card_data_out(), .host_card_data_oe_n(hoe[0]),
	.host_aux_data_1_in(hl[1]), .host_aux_data_1_out(),
	.host_aux_data_1_oe_n(hoe[1]), .host_aux_data_2_in(hl[2]),
	.host_aux_data_2_out(), .host_aux_data_2_oe_n(hoe[2]),
	.card_data_in(cl[0]), .card_data_out(), .card_data_oe_n(coe[0]),
	.card_aux_1_in(cl[1]), .card_aux_1_out(), .card_aux_1_oe_n(coe[1]),
	.card_aux_2_in(cl[2]), .card_aux_2_out(), .card_aux_2_oe_n(coe[2]),
	.host_alert_out(), .host_alert_oe_n(aoe), .card_present(present),
	.sequencer_fault(fault), .sequencer_reset_enable(sre),
	.sequencer_clock_enable(sce), .card_clock(ck), .card_reset(cr),
	.card_power_on_request(pon), .card_voltage_5v(vsel),
	.low_power_mode(lpm), .bus_address(addr), .bus_write_data(wdata),
	.bus_write(wr_s), .bus_read(rd_s), .bus_read_data(rdata),
	.interrupt(irq)
);
line_model u_line_model (.host_oe_n(hoe), .card_oe_n(coe),
	.host_pull_n(hp), .card_pull_n(cp), .host_level(hl), .card_level(cl));
function [7:0] nx(input [7:0] s);
	nx = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
endfunction
// Card clock rises in 256 cycles of a 16-cycle oscillator
function [4:0] rises(input [1:0] c);
	rises = c == 2'h0 ? 5'h02 : c == 2'h1 ? 5'h04 : c == 2'h3 ? 5'h08 : 5'h10;
endfunction
task finish_test;
begin
	$display("checks %0d errors %0d", comparisons, err_count);
	if (err_count == 0 && comparisons > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
	comparisons = comparisons + 1;
	if (got !== exp)
	begin
		err_count = err_count + 1;
		$display("[ERR] %0t got %h exp %h", $time, got, exp);
	end
end
endtask
task cyc(input integer n);
	repeat (n) @(posedge clock);
endtask
task wr(input [7:0] a, input [31:0] v);
begin
	addr <= a;
	wdata <= v;
	wr_s <= 1'b1;
	cyc(1);
	wr_s <= 1'b0;
	cyc(1);
end
endtask
task rd(input [7:0] a);
begin
	addr <= a;
	rd_s <= 1'b1;
	cyc(1);
	rd_s <= 1'b0;
	#1 d = rdata;
	cyc(1);
end
endtask
// Period of the card clock divides 256, so the count is phase free
task divrun(input [1:0] c, input [4:0] e);
	reg p;
	reg q;
	reg [4:0] n;
	reg [4:0] m;
begin
	hc[5:4] <= {c[0], c[1]};
	cyc(300);
	n = 5'h00;
	m = 5'h00;
	p = ck;
	q = ob;
	repeat (256)
	begin
		cyc(1);
		lf = nx(lf);
		strobe <= lf[0];
		if (ck && !p)
			n = n + 5'h01;
		if (ob && !q)
			m = m + 5'h01;
		p = ck;
		q = ob;
	end
	chk(n, e);
	chk(m, 5'h10);
end
endtask
initial
	forever #10 clock = ~clock;
always @(posedge clock)
	oc <= oc + 4'h1;
initial
begin
	cyc(100000);
	err_count = err_count + 1;
	finish_test;
end
initial
begin
	cyc(4);
	reset <= 1'b0;
	cyc(8);
	rd(8'h00);
	chk(d, 32'h1);
	rd(8'h10);
	chk({d, vsel, irq}, 32'h2);
	$display("reset done");
	for (i = 0; i < 4; i = i + 1)
		divrun(i[1:0], rises(i[1:0]));
	wr(8'h00, 32'h0);
	divrun(2'h2, 5'h00);
	wr(8'h00, 32'h1);
	sce <= 1'b0;
	for (i = 0; i < 4; i = i + 1)
	begin
		sre <= i[0];
		hc[1] <= i[1];
		cyc(8);
		chk({cr, ck}, {i[0] & i[1], 1'b0});
	end
	sce <= 1'b1;
	hc[6] <= 1'b1;
	for (i = 0; i < 8; i = i + 1)
	begin
		lf = nx(lf);
		strobe <= lf[0];
		hc[1] <= lf[1];
		cyc(8);
		chk({ck, cr}, {lf[0], lf[1]});
	end
	$display("modes done");
	wr(8'h08, 32'h7);
	hc <= {1'b0, lf[5:0]};
	cyc(8);
	keep = hc;
	sel <= 1'b0;
	cyc(8);
	hc <= ~keep;
	cp <= 3'h6;
	cyc(8);
	chk({vsel, pon, lpm}, {keep[3], !keep[0], keep[2] & keep[0]});
	chk({hoe, aoe}, 4'hF);
	rd(8'h04);
	chk(d & 32'h17F, {keep[5:3], keep[0], present, 1'b0, keep[6]});
	rd(8'h08);
	chk(d, 32'h4);
	sel <= 1'b1;
	hc <= keep | 7'h01;
	cp <= 3'h7;
	cyc(8);
	cp <= 3'h6;
	cyc(8);
	chk({hoe[0], hl[0]}, 2'h0);
	cp <= 3'h7;
	hp <= 3'h5;
	cyc(8);
	chk({coe[1], cl[1]}, 2'h0);
	hp <= 3'h7;
	cyc(8);
	chk({hoe, coe}, 6'h3F);
	$display("latch done");
	wr(8'h08, 32'h7);
	wr(8'h0C, 32'h7);
	present <= 1'b0;
	cyc(8);
	chk({aoe, irq}, 2'h1);
	rd(8'h08);
	chk(d, 32'h2);
	wr(8'h08, 32'h2);
	chk(irq, 1'b0);
	wr(8'h0C, 32'h0);
	present <= 1'b1;
	cyc(8);
	rd(8'h08);
	chk({d, irq}, 32'h4);
	wr(8'h08, 32'h7);
	wr(8'h0C, 32'h1);
	hc[0] <= 1'b0;
	fault <= 1'b1;
	cyc(8);
	chk({aoe, irq}, 2'h1);
	rd(8'h08);
	chk(d, 32'h1);
	$display("alert done");
	finish_test;
end
endmodule
